/* File: include/link_regs_pkg.sv */
// Constants shared by the interface link status and control register bank.
// Assumes a 32-bit AXI4-Lite bus and a PHY reporting plain status levels.
//
// Notes on behaviour
// R1 - Status bit 0 reads one while link is up, zero while down.
// R2 - Status bit 1 reads one for full duplex, zero for half.
// R3 - Outcome field bits 2-4 reads 0 while negotiating, 3 on success.
// R4 - Failed negotiation reads 1 if speed and duplex defaulted, 2 duplex only.
// R5 - Negotiation not attempted reads 4; forced speed and duplex are used.
// R6 - Status bit 5 reads one when manual settings need identity reset.
// R7 - Status bit 6 reads one when a local hardware fault is detected.
// R8 - Control bit 1 enables auto-negotiation; zero selects forced settings.
// R9 - Control bit 2 forces full duplex when negotiation is disabled.
// R10 - A 16-bit forced speed in Mbit/s applies without negotiation.
// R11 - Reserved status and control bits read zero; reserved writes ignored.
package link_regs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] status_offset  = 4'h0;
    localparam logic [3:0] control_offset = 4'h4;
    localparam logic [3:0] speed_offset   = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int link_bit       = 0;
    localparam int duplex_bit     = 1;
    localparam int outcome_lsb    = 2;
    localparam int reset_need_bit = 5;
    localparam int fault_bit      = 6;
    localparam int neg_en_bit     = 1;
    localparam int force_fd_bit   = 2;

    // ------------------------------------------------------------------
    // Outcome codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] outcome_running   = 3'h0;
    localparam logic [2:0] outcome_all_dflt  = 3'h1;
    localparam logic [2:0] outcome_dup_dflt  = 3'h2;
    localparam logic [2:0] outcome_success   = 3'h3;
    localparam logic [2:0] outcome_forced    = 3'h4;
    localparam logic [15:0] control_reset    = 16'h0002;
    localparam logic [15:0] speed_reset      = 16'h0064;
    localparam logic [15:0] control_mask     = 16'h0006;

    typedef enum logic [1:0] {
        resp_okay   = 2'h0,
        resp_slverr = 2'h2
    } resp_type;

endpackage

/* File: include/status_if.sv */
// Carries PHY status levels from the synchroniser into the register bank.
// Assumes a single clock domain on both ends.
interface status_if;
    logic       link_up;
    logic       full_duplex;
    logic       neg_done;
    logic       neg_fail_all;
    logic       neg_fail_dup;
    logic       hw_fault;

    modport source (output link_up, full_duplex, neg_done, neg_fail_all,
                    output neg_fail_dup, hw_fault);
    modport sink   (input link_up, full_duplex, neg_done, neg_fail_all,
                    input neg_fail_dup, hw_fault);
endinterface

/* File: logic/status_sync.sv */
// Two-flop synchroniser for the PHY status levels.
// Assumes the inputs are quasi-static levels from another domain.
module status_sync #(
    parameter int width = 6
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [width-1:0] async_in,
    status_if.source              stat
);
    logic [width-1:0] meta_q;
    logic [width-1:0] sync_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign stat.link_up      = sync_q[0];
    assign stat.full_duplex  = sync_q[1];
    assign stat.neg_done     = sync_q[2];
    assign stat.neg_fail_all = sync_q[3];
    assign stat.neg_fail_dup = sync_q[4];
    assign stat.hw_fault     = sync_q[5];
endmodule // status_sync

/* File: logic/status_word.sv */
// Builds the 32-bit status word from synchronised PHY state and control.
// Assumes the status interface is already in the clk domain.
module status_word (
    status_if.sink      stat,
    input  wire logic        neg_enable,
    input  wire logic        forced_fd,
    input  wire logic        reset_needed,
    output logic [31:0]      word
);
    logic [2:0] outcome;
    logic       duplex;

    // Failure is decided by the PHY; full fallback takes precedence.
    assign outcome = !neg_enable        ? link_regs_pkg::outcome_forced   // [R5]
                   : !stat.neg_done     ? link_regs_pkg::outcome_running  // [R3]
                   : stat.neg_fail_all  ? link_regs_pkg::outcome_all_dflt // [R4]
                   : stat.neg_fail_dup  ? link_regs_pkg::outcome_dup_dflt // [R4]
                   : link_regs_pkg::outcome_success;                      // [R3]
    assign duplex = neg_enable ? stat.full_duplex : forced_fd;            // [R2]

    always_comb begin
        word = 32'h0000_0000;                                      // [R11]
        word[link_regs_pkg::link_bit]       = stat.link_up;        // [R1]
        word[link_regs_pkg::duplex_bit]     = duplex;              // [R2]
        word[link_regs_pkg::outcome_lsb +: 3] = outcome;           // [R3]
        word[link_regs_pkg::reset_need_bit] = reset_needed;        // [R6]
        word[link_regs_pkg::fault_bit]      = stat.hw_fault;       // [R7]
    end
endmodule // status_word

/* File: logic/eth_link_status_control.sv */
// Register bank for one twisted-pair interface: status, control, speed.
// Assumes an AXI4-Lite master on clk and PHY status pins from outside.
module eth_link_status_control #(
    parameter bit needs_reset = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        phy_link_up,
    input  wire logic        phy_full_duplex,
    input  wire logic        phy_neg_done,
    input  wire logic        phy_neg_fail_all,
    input  wire logic        phy_neg_fail_dup,
    input  wire logic        phy_hw_fault,
    output logic             neg_enable,
    output logic             forced_full_duplex,
    output logic [15:0]      forced_speed
);
    // ------------------------------------------------------------------
    // Status path
    // ------------------------------------------------------------------
    status_if stat ();
    logic [31:0] status_val;

    status_sync #(.width(6)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({phy_hw_fault, phy_neg_fail_dup, phy_neg_fail_all,
                    phy_neg_done, phy_full_duplex, phy_link_up}),
        .stat     (stat.source)
    );

    logic [15:0] control_q;
    logic [15:0] speed_q;

    status_word u_word (
        .stat         (stat.sink),
        .neg_enable   (control_q[link_regs_pkg::neg_en_bit]),
        .forced_fd    (control_q[link_regs_pkg::force_fd_bit]),
        .reset_needed (needs_reset),
        .word         (status_val)
    );

    assign neg_enable         = control_q[link_regs_pkg::neg_en_bit];   // [R8]
    assign forced_full_duplex = control_q[link_regs_pkg::force_fd_bit]; // [R9]
    assign forced_speed       = speed_q;                                // [R10]

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    // Address and data are latched separately so either may come first.
    logic        aw_have_q;
    logic        w_have_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    wire         do_write = aw_have_q && w_have_q && !bvalid_q;
    wire         wr_ctrl  = aw_addr_q == link_regs_pkg::control_offset;
    wire         wr_speed = aw_addr_q == link_regs_pkg::speed_offset;
    wire         wr_stat  = aw_addr_q == link_regs_pkg::status_offset;
    wire [15:0]  wmask    = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_ctrl || wr_speed || wr_stat)
                             ? link_regs_pkg::resp_okay
                             : link_regs_pkg::resp_slverr;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Only control bits 1 and 2 are kept; the status word ignores writes.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_q <= link_regs_pkg::control_reset;
            speed_q   <= link_regs_pkg::speed_reset;
        end else if (do_write) begin
            if (wr_ctrl)
                control_q <= ((control_q & ~wmask) | (w_data_q[15:0] & wmask))
                             & link_regs_pkg::control_mask; // [R8] [R9] [R11]
            if (wr_speed)
                speed_q <= (speed_q & ~wmask) | (w_data_q[15:0] & wmask); // [R10]
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    wire         rd_stat  = s_axi_araddr == link_regs_pkg::status_offset;
    wire         rd_ctrl  = s_axi_araddr == link_regs_pkg::control_offset;
    wire         rd_speed = s_axi_araddr == link_regs_pkg::speed_offset;
    wire [31:0]  rd_mux   = rd_stat  ? status_val
                          : rd_ctrl  ? {16'h0000, control_q}      // [R11]
                          : rd_speed ? {16'h0000, speed_q}
                          : 32'h0000_0000;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= (rd_stat || rd_ctrl || rd_speed)
                        ? link_regs_pkg::resp_okay
                        : link_regs_pkg::resp_slverr;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // eth_link_status_control

/* File: tb/phy_model.sv */
// Link partner model: maps a negotiation state onto PHY status levels.
// Assumes the bench holds the state long enough for the synchroniser.
module phy_model (
    input  wire logic [1:0] state,
    input  wire logic       fault,
    output logic            link_up,
    output logic            full_dup,
    output logic            neg_done,
    output logic            fail_all,
    output logic            fail_dup,
    output logic            hw_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    assign link_up  = state != 2'h0;
    assign full_dup = state == 2'h3;
    assign neg_done = state != 2'h0;
    assign fail_all = state == 2'h1;
    assign fail_dup = state == 2'h2;
    assign hw_fault = fault;
endmodule // phy_model

/* File: tb/link_regs_sva.sv */
// Checker for the link register bank, on its top-level ports.
// Assumes PHY levels stay steady for several cycles around a status read.
module link_regs_sva #(
    parameter bit needs_reset = 1'h0
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        phy_link_up,
    input wire logic        phy_full_duplex,
    input wire logic        phy_neg_done,
    input wire logic        phy_neg_fail_all,
    input wire logic        phy_neg_fail_dup,
    input wire logic        phy_hw_fault,
    input wire logic        neg_enable,
    input wire logic        forced_full_duplex
);
    timeunit 1ns;
    timeprecision 1ns;
    wire rd_st = s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0;
    wire rd_ct = s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4;
    wire ok_neg = phy_neg_done && !phy_neg_fail_all && !phy_neg_fail_dup;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Read data holds the pin as it stood three edges back: two flops of
    // synchroniser, then the read register.
    property p_link; rd_st |=> s_axi_rdata[0] == $past(phy_link_up, 3);
    endproperty
    a_link: assert property (p_link) else $error("link bit wrong");
    property p_dup; rd_st && neg_enable |=>
        s_axi_rdata[1] == $past(phy_full_duplex, 3);
    endproperty
    a_dup: assert property (p_dup) else $error("duplex bit wrong");
    property p_ok; rd_st && neg_enable && ok_neg |=> s_axi_rdata[4:2] == 3'h3;
    endproperty
    a_ok: assert property (p_ok) else $error("outcome not 3");
    property p_fail; rd_st && neg_enable && phy_neg_fail_all |=>
        s_axi_rdata[4:2] == 3'h1; endproperty
    a_fail: assert property (p_fail) else $error("outcome not 1");
    property p_forced; rd_st && !neg_enable |=> s_axi_rdata[4:2] == 3'h4
        && s_axi_rdata[1] == $past(forced_full_duplex); endproperty
    a_forced: assert property (p_forced) else $error("forced wrong");
    property p_need; rd_st |=> s_axi_rdata[5] == needs_reset; endproperty
    a_need: assert property (p_need) else $error("bit5 wrong");
    property p_fault; rd_st |=> s_axi_rdata[6] == $past(phy_hw_fault, 3);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit wrong");
    property p_neg; $changed(neg_enable) |-> ##[0:1] s_axi_bvalid; endproperty
    a_neg: assert property (p_neg) else $error("control moved alone");
    // The speed word may use all 16 bits, so only status and control reads are held.
    property p_resv; rd_st |=> s_axi_rdata[31:7] == 25'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_ctl_resv; rd_ct |=> s_axi_rdata[31:3] == 29'h0
        && s_axi_rdata[0] == 1'h0; endproperty
    a_ctl_resv: assert property (p_ctl_resv) else $error("control resv set");
    c_forced: cover property (rd_st && !neg_enable);
    c_fail: cover property (rd_st && phy_neg_fail_all);
    c_write: cover property ($rose(s_axi_bvalid));
endmodule // link_regs_sva
bind eth_link_status_control link_regs_sva #(.needs_reset(needs_reset))
    sva_i (.*);

/* File: tb/tb.sv */
// Self-checking bench for the link register bank over AXI4-Lite.
// Assumes the link partner model drives the PHY status pins.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, sys_rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [1:0] state = 2'h0;
    logic fault = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire phy_link_up, phy_full_duplex, phy_neg_done, phy_neg_fail_all;
    wire phy_neg_fail_dup, phy_hw_fault, neg_enable, forced_full_duplex;
    wire [15:0] forced_speed;
    int err_total = 0, check_count = 0, cyc = 0;
    eth_link_status_control #(.needs_reset(1'h1)) uut (.*);
    phy_model pm (.state(state), .fault(fault), .link_up(phy_link_up),
        .full_dup(phy_full_duplex), .neg_done(phy_neg_done),
        .fail_all(phy_neg_fail_all), .fail_dup(phy_neg_fail_dup),
        .hw_fault(phy_hw_fault));
    always #20 clk = ~clk;
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", r, s_axi_bresp);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(4'h4, 32'h2, 2'h0);
        rd(4'h8, 32'h64, 2'h0);
        chk("neg_enable", 1'h1, neg_enable);
        $display("t_reset done");
    endtask
    task automatic t_neg();
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            e = {25'h0, i[0], 1'h1, i[2:0], i == 3, i != 0};
            state <= i[1:0];
            fault <= i[0];
            // The synchroniser needs two edges; four leave margin.
            repeat (4) @(posedge clk);
            rd(4'h0, e, 2'h0);
        end
        $display("t_neg done");
    endtask
    task automatic t_forced();
        wr(4'h4, 32'hffff_fffc, 2'h0);
        rd(4'h4, 32'h4, 2'h0);
        chk("forced_fd", 1'h1, forced_full_duplex);
        rd(4'h0, 32'h73, 2'h0);
        wr(4'h4, 32'h0, 2'h0);
        rd(4'h0, 32'h71, 2'h0);
        wr(4'h8, 32'habcd_000a, 2'h0);
        chk("speed", 16'h000a, forced_speed);
        wr(4'h4, 32'h6, 2'h0);
        state <= 2'h1;
        repeat (4) @(posedge clk);
        rd(4'h0, 32'h65, 2'h0);
        wr(4'h4, 32'h2, 2'h0);
        $display("t_forced done");
    endtask
    task automatic t_err();
        rd(4'hc, 32'h0, 2'h2);
        wr(4'hc, 32'hffff_ffff, 2'h2);
        rd(4'h8, 32'ha, 2'h0);
        wr(4'h0, 32'hffff_ffff, 2'h0);
        rd(4'h4, 32'h2, 2'h0);
        $display("t_err done");
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_neg();
        t_forced();
        t_err();
        close_out();
    end
endmodule // tb
